// >>> common/fns_pkg.sv
// Constants shared by the synthesizer control logic.
// Assumes a 20 MHz system clock and a 24-bit serial word.
`default_nettype none
package fns_pkg;
  localparam int unsigned SYS_CLK_HZ     = 20_000_000;
  localparam int unsigned WORD_W         = 24;
  // Address field and word selects
  localparam int unsigned ADDR_HI        = 23;
  localparam int unsigned ADDR_LO        = 22;
  localparam logic [1:0]  ADDR_A         = 2'h0;
  localparam logic [1:0]  ADDR_B         = 2'h1;
  localparam logic [1:0]  ADDR_C         = 2'h2;
  // A word fields
  localparam int unsigned A_FMOD_POS     = 21;
  localparam int unsigned A_NF_LO        = 18;
  localparam int unsigned A_N_LO         = 2;
  localparam logic [21:0] A_DEFAULT      = 22'h08_88C0;
  // B word fields
  localparam int unsigned B_R_LO         = 12;
  localparam int unsigned B_PD_MAIN_POS  = 9;
  localparam int unsigned B_PD_AUX_POS   = 8;
  localparam int unsigned B_FC_LO        = 0;
  localparam logic [21:0] B_DEFAULT      = 22'h05_1350;
  // C word fields
  localparam int unsigned C_SM_LO        = 19;
  localparam int unsigned C_SA_LO        = 16;
  localparam int unsigned C_CP1_POS      = 15;
  localparam int unsigned C_CP0_POS      = 14;
  localparam int unsigned C_AUX_LO       = 0;
  localparam logic [21:0] C_DEFAULT      = 22'h00_0100;
  // Divider limits
  localparam logic [13:0] AUX_RATIO_MIN  = 14'h0080;
  localparam logic [9:0]  REF_RATIO_MIN  = 10'h004;
  localparam logic [3:0]  MOD_Q5         = 4'h5;
  localparam logic [3:0]  MOD_Q8         = 4'h8;
  // Timing
  localparam logic [7:0]  COMP_VCO_CYC   = 8'h80;
  localparam int unsigned BACKLASH_NS    = 100;
  localparam int unsigned BACKLASH_CYC   =
    (BACKLASH_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
endpackage
`default_nettype wire

// >>> hw/fns_serial_link.sv
// Serial shift register on the programming clock.
// Assumes host changes data and strobe relative to the serial clock.
`timescale 1ns/10ps
`default_nettype none
module fns_serial_link
  import fns_pkg::*;
(
  input  wire logic              serial_clk_in,
  input  wire logic              reset_in,
  input  wire logic              serial_data_in,
  input  wire logic              serial_strobe_in,
  output logic [WORD_W-1:0]      shift_out
);
  logic [WORD_W-1:0] shift_q;

  // Frozen while strobe is high, so the system side may read it then
  always_ff @(posedge serial_clk_in or posedge reset_in) begin
    if (reset_in) begin
      shift_q <= '0;
    end else if (!serial_strobe_in) begin
      shift_q <= {serial_data_in, shift_q[WORD_W-1:1]};
    end
  end

  assign shift_out = shift_q;

  property p_shift_hold;
    @(posedge serial_clk_in) disable iff (reset_in)
      serial_strobe_in |=> $stable(shift_q);
  endproperty
  a_shift_hold: assert property (p_shift_hold)
    else $error("shift register moved while strobe high");
endmodule
`default_nettype wire

// >>> hw/fns_pfd.sv
// Phase/frequency detector with backlash and lock measurement.
// Assumes single-cycle reference, divider and ref-input ticks.
`timescale 1ns/10ps
`default_nettype none
module fns_pfd
  import fns_pkg::*;
#(
  parameter int unsigned BL_CYC = BACKLASH_CYC
)(
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic enable_in,
  input  wire logic ref_pulse_in,
  input  wire logic div_pulse_in,
  input  wire logic ref_tick_in,
  output logic      up_out,
  output logic      down_out,
  output logic      locked_out
);
  logic       up_q;
  logic       dn_q;
  logic [3:0] bl_cnt_q;
  logic [1:0] err_cnt_q;
  logic       locked_q;
  logic       both;
  logic       bl_done;

  assign both    = up_q && dn_q;
  assign bl_done = both && (bl_cnt_q == 4'(BL_CYC - 1));

  // Both pumps held on for the backlash time each comparison
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      up_q     <= 1'b0;
      dn_q     <= 1'b0;
      bl_cnt_q <= 4'h0;
    end else if (!enable_in) begin
      up_q     <= 1'b0;
      dn_q     <= 1'b0;
      bl_cnt_q <= 4'h0;
    end else if (bl_done) begin
      up_q     <= ref_pulse_in;
      dn_q     <= div_pulse_in;
      bl_cnt_q <= 4'h0;
    end else begin
      up_q     <= up_q || ref_pulse_in;
      dn_q     <= dn_q || div_pulse_in;
      bl_cnt_q <= both ? bl_cnt_q + 4'h1 : 4'h0;
    end
  end

  // Lock when single-sided error stays under one ref-input period
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      err_cnt_q <= 2'h0;
      locked_q  <= 1'b0;
    end else if (!enable_in) begin
      err_cnt_q <= 2'h0;
      locked_q  <= 1'b0;
    end else if (bl_done) begin
      locked_q  <= (err_cnt_q == 2'h0);
      err_cnt_q <= 2'h0;
    end else if ((up_q ^ dn_q) && ref_tick_in && err_cnt_q != 2'h3) begin
      err_cnt_q <= err_cnt_q + 2'h1;
    end
  end

  assign up_out     = up_q;
  assign down_out   = dn_q;
  assign locked_out = locked_q;

  property p_backlash;
    @(posedge clk_sys_in) disable iff (reset_in)
      $rose(up_q && dn_q) && enable_in |-> (up_q && dn_q)[*2];
  endproperty
  a_backlash: assert property (p_backlash)
    else $error("backlash interval too short");

  property p_pfd_off;
    @(posedge clk_sys_in) disable iff (reset_in)
      !enable_in |=> !up_q && !dn_q && !locked_q;
  endproperty
  a_pfd_off: assert property (p_pfd_off)
    else $error("detector active while powered down");
endmodule
`default_nettype wire

// >>> hw/fns_synth_ctrl.sv
// Digital control of a dual fractional-N synthesizer.
// Assumes divider and serial pins are asynchronous to clk_sys_in and
// that VCO/aux/ref edges are slow enough to be sampled here.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Auxiliary divider divides by programmed ratio, 128 to 16383.
// - Reference divider 4 to 1023 feeds a three-bit pulse counter.
// - Main and aux select fields pick one of five reference pulses.
// - Each detector holds both pumps on for a backlash time per cycle.
// - Main pumps follow main detector; aux pump follows aux detector.
// - Speed-up starts after A word loads with strobe high; ends strobe low.
// - Upper gain bit kills integral pump; lower bit picks reduced current.
// - Compensation pulse lasts 128 VCO cycles, amplitude accumulator times DAC.
// - Lock output needs both detectors locked within one ref period.
// - One loop off: other decides lock; both off: lock low.
// - Loop power is hardware pin XOR software bit.
// - Leaving power-down resynchronises main and reference dividers.
// - DAC bits from B wait in temporary register until A loads.
// - Words are 24 bits with address bits choosing the register.
// - Strobe high freezes shifting and latches word by address.
// - Accumulator adds increment modulo 5 or 8; overflow divides by N+1.
// - A word holds address 00, modulus bit, increment and 16-bit ratio.
// - New main ratio takes effect at a main divider boundary.
module fns_synth_ctrl
  import fns_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        serial_clk_in,
  input  wire logic        serial_data_in,
  input  wire logic        serial_strobe_in,
  input  wire logic        vco_in,
  input  wire logic        aux_rf_input_in,
  input  wire logic        ref_in,
  input  wire logic        hw_power_pin_in,
  output logic             main_prop_pump_up_out,
  output logic             main_prop_pump_dn_out,
  output logic             main_integral_pump_up_out,
  output logic             main_integral_pump_dn_out,
  output logic             aux_pump_out_up_out,
  output logic             aux_pump_out_dn_out,
  output logic             pump_gain_low_sel_out,
  output logic             speedup_out,
  output logic             comp_active_out,
  output logic [10:0]      comp_amp_out,
  output logic [2:0]       frac_accum_value_out,
  output logic             lock_out,
  output logic             main_on_out,
  output logic             aux_on_out
);
  localparam int unsigned NPIN = 5;
  localparam int unsigned P_VCO = 0;
  localparam int unsigned P_AUX = 1;
  localparam int unsigned P_REF = 2;
  localparam int unsigned P_STB = 3;
  localparam int unsigned P_PWR = 4;

  // Pin synchronisers and edge detection
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [NPIN-1:0] prev_q;
  logic [NPIN-1:0] rise;

  assign pin_raw = {hw_power_pin_in, serial_strobe_in, ref_in, aux_rf_input_in, vco_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          prev_q[gi]  <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi]  <= sync2_q[gi];
        end
      end
      assign rise[gi] = sync2_q[gi] && !prev_q[gi];
    end
  endgenerate

  // Serial link on its own clock
  logic [WORD_W-1:0] shift_word;

  fns_serial_link u_link (
    .serial_clk_in   (serial_clk_in),
    .reset_in        (reset_in),
    .serial_data_in  (serial_data_in),
    .serial_strobe_in(serial_strobe_in),
    .shift_out       (shift_word)
  );

  // Word registers; shift word is static while strobe is high
  logic [21:0] a_work_q;
  logic [21:0] b_work_q;
  logic [21:0] c_work_q;
  logic [7:0]  fc_tmp_q;
  logic [7:0]  fc_work_q;
  logic [1:0]  addr;
  logic        a_load;
  logic        b_load;
  logic        c_load;

  assign addr   = shift_word[ADDR_HI:ADDR_LO];
  assign a_load = rise[P_STB] && addr == ADDR_A;
  assign b_load = rise[P_STB] && addr == ADDR_B;
  assign c_load = rise[P_STB] && addr == ADDR_C;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      a_work_q  <= A_DEFAULT;
      b_work_q  <= B_DEFAULT;
      c_work_q  <= C_DEFAULT;
      fc_tmp_q  <= B_DEFAULT[B_FC_LO +: 8];
      fc_work_q <= B_DEFAULT[B_FC_LO +: 8];
    end else begin
      if (a_load) begin
        a_work_q  <= shift_word[21:0];
        fc_work_q <= fc_tmp_q;
      end
      if (b_load) begin
        b_work_q <= shift_word[21:0];
        fc_tmp_q <= shift_word[B_FC_LO +: 8];
      end
      if (c_load) begin
        c_work_q <= shift_word[21:0];
      end
    end
  end

  // Power state
  logic main_on;
  logic aux_on;
  logic main_on_q;
  logic aux_on_q;
  logic resync;

  assign main_on = sync2_q[P_PWR] ^ b_work_q[B_PD_MAIN_POS];
  assign aux_on  = sync2_q[P_PWR] ^ b_work_q[B_PD_AUX_POS];
  assign resync  = (main_on && !main_on_q) || (aux_on && !aux_on_q);

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      main_on_q <= 1'b0;
      aux_on_q  <= 1'b0;
    end else begin
      main_on_q <= main_on;
      aux_on_q  <= aux_on;
    end
  end

  // Ratio floor; out-of-range programming is pulled to the minimum
  function automatic logic [13:0] floor_ratio(input logic [13:0] v, input logic [13:0] lo);
    floor_ratio = (v < lo) ? lo : v;
  endfunction

  // One of five reference pulses
  function automatic logic pick_pulse(input logic [2:0] sel, input logic term,
                                      input logic [2:0] bin);
    case (sel)
      3'h0:    pick_pulse = term;
      3'h1:    pick_pulse = term && bin[0] == 1'b0;
      3'h2:    pick_pulse = term && bin[1:0] == 2'h0;
      3'h3:    pick_pulse = term && bin == 3'h0;
      default: pick_pulse = term && bin == 3'h4;
    endcase
  endfunction

  // Reference divider and three-bit counter
  logic [9:0]  ref_cnt_q;
  logic [2:0]  ref_bin_q;
  logic [13:0] ref_ratio;
  logic        ref_term;
  logic        ref_main_pulse;
  logic        ref_aux_pulse;

  assign ref_ratio = floor_ratio({4'h0, b_work_q[B_R_LO +: 10]}, {4'h0, REF_RATIO_MIN});
  assign ref_term  = rise[P_REF] && ({4'h0, ref_cnt_q} == ref_ratio - 14'h1);

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ref_cnt_q <= 10'h000;
      ref_bin_q <= 3'h0;
    end else if (resync) begin
      ref_cnt_q <= 10'h000;
      ref_bin_q <= 3'h0;
    end else if (ref_term) begin
      ref_cnt_q <= 10'h000;
      ref_bin_q <= ref_bin_q + 3'h1;
    end else if (rise[P_REF]) begin
      ref_cnt_q <= ref_cnt_q + 10'h001;
    end
  end

  assign ref_main_pulse = pick_pulse(c_work_q[C_SM_LO +: 3], ref_term, ref_bin_q);
  assign ref_aux_pulse  = pick_pulse(c_work_q[C_SA_LO +: 3], ref_term, ref_bin_q);

  // Main fractional-N divider
  logic [16:0] main_cnt_q;
  logic [15:0] n_cur_q;
  logic        carry_q;
  logic [3:0]  acc_q;
  logic [16:0] main_target;
  logic        main_term;
  logic [3:0]  mod_q;
  logic [3:0]  acc_sum;

  assign main_target = {1'b0, n_cur_q} + {16'h0000, carry_q};
  assign main_term   = rise[P_VCO] && (main_cnt_q == main_target - 17'h1);
  assign mod_q       = a_work_q[A_FMOD_POS] ? MOD_Q5 : MOD_Q8;
  assign acc_sum     = acc_q + {1'b0, a_work_q[A_NF_LO +: 3]};

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      main_cnt_q <= 17'h00000;
      n_cur_q    <= A_DEFAULT[A_N_LO +: 16];
      carry_q    <= 1'b0;
      acc_q      <= 4'h0;
    end else if (resync) begin
      main_cnt_q <= 17'h00000;
    end else if (main_term) begin
      main_cnt_q <= 17'h00000;
      n_cur_q    <= a_work_q[A_N_LO +: 16];
      if (acc_sum >= mod_q) begin
        acc_q   <= acc_sum - mod_q;
        carry_q <= 1'b1;
      end else begin
        acc_q   <= acc_sum;
        carry_q <= 1'b0;
      end
    end else if (rise[P_VCO]) begin
      main_cnt_q <= main_cnt_q + 17'h00001;
    end
  end

  // Fractional compensation pulse, timed in VCO cycles
  logic [7:0]  comp_cnt_q;
  logic [10:0] comp_amp_q;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      comp_cnt_q <= 8'h00;
      comp_amp_q <= 11'h000;
    end else if (main_term) begin
      comp_cnt_q <= COMP_VCO_CYC;
      comp_amp_q <= 11'(acc_q[2:0]) * 11'(fc_work_q);
    end else if (rise[P_VCO] && comp_cnt_q != 8'h00) begin
      comp_cnt_q <= comp_cnt_q - 8'h01;
    end
  end

  // Auxiliary divider
  logic [13:0] aux_cnt_q;
  logic [13:0] aux_ratio;
  logic        aux_term;

  assign aux_ratio = floor_ratio(c_work_q[C_AUX_LO +: 14], AUX_RATIO_MIN);
  assign aux_term  = rise[P_AUX] && (aux_cnt_q == aux_ratio - 14'h1);

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      aux_cnt_q <= 14'h0000;
    end else if (aux_term) begin
      aux_cnt_q <= 14'h0000;
    end else if (rise[P_AUX]) begin
      aux_cnt_q <= aux_cnt_q + 14'h0001;
    end
  end

  // Phase detectors
  logic main_up;
  logic main_dn;
  logic main_lock;
  logic aux_up;
  logic aux_dn;
  logic aux_lock;

  fns_pfd u_main_pfd (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (reset_in),
    .enable_in   (main_on),
    .ref_pulse_in(ref_main_pulse),
    .div_pulse_in(main_term),
    .ref_tick_in (rise[P_REF]),
    .up_out      (main_up),
    .down_out    (main_dn),
    .locked_out  (main_lock)
  );

  fns_pfd u_aux_pfd (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (reset_in),
    .enable_in   (aux_on),
    .ref_pulse_in(ref_aux_pulse),
    .div_pulse_in(aux_term),
    .ref_tick_in (rise[P_REF]),
    .up_out      (aux_up),
    .down_out    (aux_dn),
    .locked_out  (aux_lock)
  );

  // Speed-up and lock
  logic speedup_q;
  logic lock_q;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      speedup_q <= 1'b0;
    end else if (!sync2_q[P_STB]) begin
      speedup_q <= 1'b0;
    end else if (a_load) begin
      speedup_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      lock_q <= 1'b0;
    end else begin
      case ({main_on, aux_on})
        2'h3:    lock_q <= main_lock && aux_lock;
        2'h2:    lock_q <= main_lock;
        2'h1:    lock_q <= aux_lock;
        default: lock_q <= 1'b0;
      endcase
    end
  end

  // Pump steering
  assign main_prop_pump_up_out     = main_up;
  assign main_prop_pump_dn_out     = main_dn;
  assign main_integral_pump_up_out = main_up && !c_work_q[C_CP1_POS];
  assign main_integral_pump_dn_out = main_dn && !c_work_q[C_CP1_POS];
  assign aux_pump_out_up_out       = aux_up;
  assign aux_pump_out_dn_out       = aux_dn;
  assign pump_gain_low_sel_out     = c_work_q[C_CP0_POS];
  assign speedup_out               = speedup_q;
  assign comp_active_out           = comp_cnt_q != 8'h00;
  assign comp_amp_out              = comp_amp_q;
  assign frac_accum_value_out      = acc_q[2:0];
  assign lock_out                  = lock_q;
  assign main_on_out               = main_on;
  assign aux_on_out                = aux_on;

  property p_lock_off;
    @(posedge clk_sys_in) disable iff (reset_in)
      !main_on && !aux_on |=> !lock_out;
  endproperty
  a_lock_off: assert property (p_lock_off)
    else $error("lock high with both loops off");

  property p_speedup_exit;
    @(posedge clk_sys_in) disable iff (reset_in)
      !sync2_q[P_STB] |=> !speedup_out;
  endproperty
  a_speedup_exit: assert property (p_speedup_exit)
    else $error("speed-up held after strobe low");

  property p_integral_off;
    @(posedge clk_sys_in) disable iff (reset_in)
      c_work_q[C_CP1_POS] |-> !main_integral_pump_up_out && !main_integral_pump_dn_out;
  endproperty
  a_integral_off: assert property (p_integral_off)
    else $error("integral pump active while disabled");

  property p_comp_start;
    @(posedge clk_sys_in) disable iff (reset_in)
      main_term |=> comp_cnt_q == 8'h80 && comp_active_out;
  endproperty
  a_comp_start: assert property (p_comp_start)
    else $error("compensation pulse not 128 VCO cycles");

  property p_fc_temp;
    @(posedge clk_sys_in) disable iff (reset_in)
      b_load && !a_load |=> $stable(fc_work_q);
  endproperty
  a_fc_temp: assert property (p_fc_temp)
    else $error("DAC setting applied before A word");

  property p_fc_copy;
    @(posedge clk_sys_in) disable iff (reset_in)
      a_load |=> fc_work_q == $past(fc_tmp_q);
  endproperty
  a_fc_copy: assert property (p_fc_copy)
    else $error("DAC temporary not copied on A word");
endmodule
`default_nettype wire

// >>> verification/fns_host_model.sv
// Host side of the three-wire programming bus.
// Assumes the testbench calls its tasks one at a time.
`timescale 1ns/10ps
`default_nettype none
module fns_host_model (
  output logic serial_clk_out,
  output logic serial_data_out,
  output logic serial_strobe_out
);
  // Clock stands still low outside frames
  initial begin
    serial_clk_out    = 1'b0;
    serial_data_out   = 1'b0;
    serial_strobe_out = 1'b0;
  end
  // Low time well over 4 system cycles before clocking
  task automatic lower_strobe();
    serial_strobe_out = 1'b0;
    #250;
  endtask
  // Bit0 first, 80 ns serial period
  task automatic send_word(input logic [23:0] word);
    if (serial_strobe_out) lower_strobe();
    for (int i = 0; i < 24; i++) begin
      serial_data_out = word[i];
      #40 serial_clk_out = 1'b1;
      #40 serial_clk_out = 1'b0;
    end
    // Data released, no pull: show the inverse
    serial_data_out = ~word[23];
    #40 serial_strobe_out = 1'b1;
    // Stray clock while strobe is high; the word must not move
    #40 serial_clk_out = 1'b1;
    #40 serial_clk_out = 1'b0;
    #320;
  endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the synthesizer control block.
// Assumes the host model drives the serial pins on its own clock.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fns_pkg::*;
  logic        clk_sys_in, reset_in, hw_power_pin_in;
  logic        s_clk, s_data, s_strobe;
  logic        mp_up, mp_dn, mi_up, mi_dn, ax_up, ax_dn;
  logic        gain_low, speedup, comp_active, lock, main_on, aux_on;
  logic [10:0] comp_amp;
  logic [2:0]  acc;
  logic [7:0]  stim_cnt;
  int          num_errors, checked, cycles, mp_n, mi_n, bm_n, ba_n;

  fns_host_model host (.serial_clk_out(s_clk), .serial_data_out(s_data),
    .serial_strobe_out(s_strobe));
  fns_synth_ctrl dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .serial_clk_in(s_clk), .serial_data_in(s_data), .serial_strobe_in(s_strobe),
    .vco_in(stim_cnt[1]), .aux_rf_input_in(stim_cnt[1]), .ref_in(stim_cnt[2]),
    .hw_power_pin_in(hw_power_pin_in), .main_prop_pump_up_out(mp_up),
    .main_prop_pump_dn_out(mp_dn), .main_integral_pump_up_out(mi_up),
    .main_integral_pump_dn_out(mi_dn), .aux_pump_out_up_out(ax_up),
    .aux_pump_out_dn_out(ax_dn), .pump_gain_low_sel_out(gain_low),
    .speedup_out(speedup), .comp_active_out(comp_active), .comp_amp_out(comp_amp),
    .frac_accum_value_out(acc), .lock_out(lock), .main_on_out(main_on),
    .aux_on_out(aux_on));

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // Divider inputs slow enough for the synchronisers
  always @(posedge clk_sys_in) begin
    #1 stim_cnt = stim_cnt + 8'h01;
  end
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      $display("Error at %0t: run hung", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  function automatic logic [23:0] word_a(logic fm, logic [2:0] nf, logic [15:0] n);
    return {ADDR_A, fm, nf, n, 2'b00};
  endfunction
  function automatic logic [23:0] word_b(logic pdm, logic pda, logic [7:0] fc);
    return {ADDR_B, 10'h004, 2'b00, pdm, pda, fc};
  endfunction
  function automatic logic [23:0] word_c(logic cp1, logic cp0);
    return {ADDR_C, 3'h0, 3'h0, cp1, cp0, 14'h00C8};
  endfunction
  task automatic watch(input int n);
    mp_n = 0; mi_n = 0; bm_n = 0; ba_n = 0;
    repeat (n) begin
      cyc(1);
      mp_n += int'(mp_up === 1'b1 || mp_dn === 1'b1);
      mi_n += int'(mi_up === 1'b1 || mi_dn === 1'b1);
      bm_n += int'(mp_up === 1'b1 && mp_dn === 1'b1);
      ba_n += int'(ax_up === 1'b1 && ax_dn === 1'b1);
    end
  endtask

  task automatic t_power();
    check(main_on === 1'b1 && aux_on === 1'b1, "loops off after reset");
    check(lock === 1'b0 && speedup === 1'b0, "lock or speed-up after reset");
    hw_power_pin_in = 1'b1;
    cyc(20);
    check(main_on === 1'b0 && aux_on === 1'b0, "pin did not invert power");
    check(lock === 1'b0, "lock high with both loops off");
    hw_power_pin_in = 1'b0;
    cyc(5);
  endtask
  task automatic t_frac();
    logic [2:0] old;
    logic       ovf, ovf_prev;
    int         hi, gap, hi_prev;
    host.send_word(word_c(1'b0, 1'b0));
    host.send_word(word_b(1'b0, 1'b1, 8'h80));
    host.send_word(word_a(1'b1, 3'h3, 16'h0200));
    check(speedup === 1'b1, "no speed-up after A word");
    host.lower_strobe();
    check(speedup === 1'b0, "speed-up held after strobe low");
    host.send_word(word_b(1'b1, 1'b1, 8'h80));
    ovf_prev = 1'b0;
    hi_prev  = 0;
    for (int k = 0; k < 4; k++) begin
      old = acc;
      ovf = (old + 3'h3) >= 3'h5;
      gap = 0;
      while (comp_active !== 1'b1) begin
        cyc(1);
        gap++;
      end
      // Restart: default ratio of 8752 VCO edges, 4 system cycles each
      if (k == 0) check(gap >= 35000 && gap <= 35008, "restart not synchronised");
      else check(hi_prev + gap == (ovf_prev ? 2052 : 2048), "divide ratio wrong");
      check(acc === (old + 3'h3) % 3'h5, "accumulator step wrong");
      check(comp_amp === 11'(old) * 11'h080, "compensation amplitude wrong");
      hi = 0;
      while (comp_active === 1'b1) begin
        cyc(1);
        hi++;
      end
      check(hi >= 508 && hi <= 516, "compensation width wrong");
      hi_prev  = hi;
      ovf_prev = ovf;
    end
  endtask
  task automatic t_gain();
    check(gain_low === 1'b0, "gain bit set early");
    host.send_word(word_c(1'b1, 1'b1));
    check(gain_low === 1'b1, "low gain not selected");
    host.send_word({2'b11, 22'h000000});
    check(gain_low === 1'b1, "D word changed C bits");
    watch(3000);
    check(bm_n > 0, "no main backlash overlap");
    check(mi_n == 0, "integral pump not disabled");
  endtask
  task automatic t_pumps();
    host.send_word(word_b(1'b0, 1'b1, 8'h80));
    check(main_on === 1'b0 && aux_on === 1'b1, "power bits not applied");
    watch(3000);
    check(mp_n == 0 && bm_n == 0, "main pumps moved with loop off");
    check(ba_n > 0, "no aux backlash overlap");
    check(lock === 1'b0, "lock with aux loop far off frequency");
  endtask

  initial begin
    reset_in        = 1'b1;
    hw_power_pin_in = 1'b0;
    stim_cnt        = 8'h00;
    num_errors      = 0;
    checked         = 0;
    cycles          = 0;
    cyc(20);
    reset_in = 1'b0;
    cyc(5);
    t_power();
    t_frac();
    t_gain();
    t_pumps();
    end_of_test();
  end
endmodule
`default_nettype wire
